// ---- inc/bms_consts.svh ----
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

// Internal oscillator frequency after reset, in MHz
`define BMS_INT_OSC_MHZ      10
// Option byte width and clock mode field
`define BMS_OPT_W            8
`define BMS_CLK_FIELD_LSB    0
`define BMS_CLK_FIELD_W      2
// Option byte reset value (internal oscillator)
`define BMS_OPT_RST          8'h00
// Clock mode encodings
`define BMS_CLK_INTERNAL     2'h0
`define BMS_CLK_EXTERNAL     2'h1
`define BMS_CLK_QUARTZ       2'h2
`define BMS_CLK_RC           2'h3
// Number of option bytes
`define BMS_OPT_NUM          4
`define BMS_OPT_AW           2

`endif

// ---- inc/bms_pkg.sv ----
package bms_pkg;

  typedef enum logic [1:0] {
    BMS_CLK_INT,
    BMS_CLK_EXT,
    BMS_CLK_XTAL,
    BMS_CLK_RCO
  } bms_clk_mode_t;

  typedef enum logic {
    BMS_MODE_WORK,
    BMS_MODE_PROG
  } bms_mode_t;

endpackage : bms_pkg

// ---- src/bms_boot_mode_select.sv ----
`timescale 1ns/1ps
`include "bms_consts.svh"
// Contract
// - Mode changes only through reset
// - Option bytes writable only in programming
// - Programming traffic goes over I2C
// - Programming mode runs from internal clock
// - Boot internal, then apply stored clock mode
module bms_boot_mode_select
  import bms_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      prog_sel_pin,
  input  wire logic                      i2c_opt_wr,
  input  wire logic [`BMS_OPT_AW-1:0]    i2c_opt_addr,
  input  wire logic [`BMS_OPT_W-1:0]     i2c_opt_wdata,
  input  wire logic                      i2c_sda_in,
  input  wire logic                      i2c_scl_in,
  output logic                           prog_mode,
  output logic                           i2c_prog_en,
  output logic                           boot_done,
  output logic [1:0]                     clk_mode,
  output logic                           opt_wr_ack,
  output logic [`BMS_OPT_W-1:0]          opt_byte0,
  output logic                           i2c_sda_prog,
  output logic                           i2c_scl_prog
);

  typedef enum logic [1:0] {
    BMS_ST_SYNC,
    BMS_ST_LATCH,
    BMS_ST_READ_OPT,
    BMS_ST_RUN
  } bms_state_t;

  logic                     rst_s1_q;
  logic                     rst_n_q;
  logic [2:0]               sel_sync_q;
  logic [2:0]               sel_sync_d;
  logic                     sel_stable_q;
  logic                     sel_stable_d;
  bms_state_t               state_q;
  bms_state_t               state_d;
  bms_mode_t                mode_q;
  bms_mode_t                mode_d;
  logic [1:0]               clk_mode_q;
  logic [1:0]               clk_mode_d;
  logic                     ack_q;
  logic                     ack_d;
  logic [`BMS_OPT_W-1:0]    opt_mem_q [`BMS_OPT_NUM];
  logic [`BMS_OPT_W-1:0]    opt_mem_d [`BMS_OPT_NUM];

  // Internal decodes
  logic                     opt_wr_ok;
  logic [`BMS_OPT_NUM-1:0]  opt_sel;
  logic                     prog_now;
  logic                     run_now;

  // Mode decode, shared by the write gate, the bus gate and the boot clock
  function automatic logic bms_is_prog(
    input bms_mode_t m
  );
    return (m == BMS_MODE_PROG);
  endfunction : bms_is_prog

  // Clock mode applied at the end of boot
  function automatic logic [1:0] bms_boot_clk(
    input bms_mode_t             m,
    input logic [`BMS_OPT_W-1:0] b
  );
    logic [1:0] f;
    f = b[`BMS_CLK_FIELD_LSB +: `BMS_CLK_FIELD_W];
    if (bms_is_prog(m)) begin
      f = `BMS_CLK_INTERNAL;
    end
    return f;
  endfunction : bms_boot_clk

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Three-stage pin synchroniser; each stage reads only the one before
  assign sel_sync_d[0] = prog_sel_pin;
  for (genvar s = 1; s < 3; s++) begin : g_sel_sync
    assign sel_sync_d[s] = sel_sync_q[s-1];
  end

  // Level counts once the second and third stages agree
  always_comb begin
    sel_stable_d = sel_stable_q;
    if (sel_sync_q[1] == sel_sync_q[2]) begin
      sel_stable_d = sel_sync_q[2];
    end
  end

  // No reset: the pin is tracked while reset is held, so its level has
  // settled in every stage before the latch reads it after release
  always_ff @(posedge mclk) begin
    sel_sync_q   <= sel_sync_d;
    sel_stable_q <= sel_stable_d;
  end

  // Boot sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BMS_ST_SYNC: begin
        state_d = BMS_ST_LATCH;
      end
      BMS_ST_LATCH: begin
        state_d = BMS_ST_READ_OPT;
      end
      BMS_ST_READ_OPT: begin
        state_d = BMS_ST_RUN;
      end
      BMS_ST_RUN: begin
        state_d = BMS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= BMS_ST_SYNC;
    end else begin
      state_q <= state_d;
    end
  end

  // Mode latch, taken once per reset and held until the next one
  always_comb begin
    mode_d = mode_q;
    if (state_q == BMS_ST_LATCH) begin
      mode_d = sel_stable_q ? BMS_MODE_PROG : BMS_MODE_WORK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= BMS_MODE_WORK;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Clock mode: internal from reset, stored mode applied after the latch in working mode only
  always_comb begin
    clk_mode_d = clk_mode_q;
    if (state_q == BMS_ST_LATCH) begin
      clk_mode_d = `BMS_CLK_INTERNAL;
    end
    if (state_q == BMS_ST_READ_OPT) begin
      clk_mode_d = bms_boot_clk(mode_q, opt_mem_q[0]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_mode_q <= `BMS_CLK_INTERNAL;
    end else begin
      clk_mode_q <= clk_mode_d;
    end
  end

  // Option byte writes, only after a programming boot
  assign opt_wr_ok = run_now && prog_now && i2c_opt_wr;

  // One write select per option byte
  for (genvar g = 0; g < `BMS_OPT_NUM; g++) begin : g_opt_sel
    assign opt_sel[g] = opt_wr_ok && (int'(i2c_opt_addr) == g);
  end

  always_comb begin
    for (int i = 0; i < `BMS_OPT_NUM; i++) begin
      opt_mem_d[i] = opt_sel[i] ? i2c_opt_wdata : opt_mem_q[i];
    end
  end

  // Write acknowledge, raised on the same edge the byte lands
  always_comb begin
    ack_d = opt_wr_ok;
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Option bytes keep their contents across reset
  always_ff @(posedge mclk) begin
    for (int i = 0; i < `BMS_OPT_NUM; i++) begin
      opt_mem_q[i] <= opt_mem_d[i];
    end
  end

  assign prog_now     = bms_is_prog(mode_q);
  assign run_now      = (state_q == BMS_ST_RUN);

  // Bus lines reach the loader only after a programming boot, so
  // traffic seen in working mode never touches the option bytes
  assign i2c_prog_en  = prog_now && run_now;
  assign i2c_sda_prog = i2c_sda_in & i2c_prog_en;
  assign i2c_scl_prog = i2c_scl_in & i2c_prog_en;

  // Status outputs
  assign prog_mode    = prog_now;
  assign boot_done    = run_now;
  assign clk_mode     = clk_mode_q;
  assign opt_wr_ack   = ack_q;
  assign opt_byte0    = opt_mem_q[0];

endmodule : bms_boot_mode_select

// ---- verif/bms_chk_asserts.sv ----
`timescale 1ns/1ps
module bms_chk (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       i2c_opt_wr,
  input wire logic [1:0] i2c_opt_addr,
  input wire logic [7:0] i2c_opt_wdata,
  input wire logic       i2c_sda_in,
  input wire logic       prog_mode,
  input wire logic       i2c_prog_en,
  input wire logic       boot_done,
  input wire logic [1:0] clk_mode,
  input wire logic       opt_wr_ack,
  input wire logic [7:0] opt_byte0,
  input wire logic       i2c_sda_prog
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_boot_work;
    $rose(boot_done) && !prog_mode;
  endsequence
  AST_MODE_HOLD: assert property (boot_done |=> boot_done && $stable(prog_mode))
    else $error("mode changed without reset");
  AST_WR_WORK: assert property (boot_done && !prog_mode && i2c_opt_wr
    |=> !opt_wr_ack && $stable(opt_byte0)) else $error("write taken in working mode");
  AST_WR_PROG: assert property (boot_done && prog_mode && i2c_opt_wr && i2c_opt_addr == 2'h0
    |=> opt_wr_ack && opt_byte0 == $past(i2c_opt_wdata)) else $error("write lost");
  AST_GATE: assert property (boot_done && prog_mode |-> i2c_prog_en
    && i2c_sda_prog == i2c_sda_in) else $error("bus not passed");
  AST_CLK_PROG: assert property (boot_done && prog_mode |-> clk_mode == 2'h0)
    else $error("external clock in programming");
  AST_BOOT_INT: assert property (!boot_done |-> clk_mode == 2'h0 && !i2c_prog_en)
    else $error("boot not on internal clock");
  AST_BOOT_APPLY: assert property (s_boot_work |-> clk_mode == opt_byte0[1:0])
    else $error("stored clock mode not applied");
endmodule : bms_chk
bind bms_boot_mode_select bms_chk u_chk (
  .mclk          (mclk),
  .resetn        (resetn),
  .i2c_opt_wr    (i2c_opt_wr),
  .i2c_opt_addr  (i2c_opt_addr),
  .i2c_opt_wdata (i2c_opt_wdata),
  .i2c_sda_in    (i2c_sda_in),
  .prog_mode     (prog_mode),
  .i2c_prog_en   (i2c_prog_en),
  .boot_done     (boot_done),
  .clk_mode      (clk_mode),
  .opt_wr_ack    (opt_wr_ack),
  .opt_byte0     (opt_byte0),
  .i2c_sda_prog  (i2c_sda_prog)
);

// ---- verif/bms_tool.sv ----
`timescale 1ns/1ps
module bms_tool (
  input  wire logic mclk,
  input  wire logic want,
  output logic      sel,
  output logic      sda,
  output logic      scl
);
  logic sda_q = 1'b1;
  assign sel = want;
  assign scl = 1'b1;
  assign sda = sda_q;
  always @(negedge mclk) sda_q <= ~sda_q;
endmodule : bms_tool

// ---- verif/bms_boot_mode_select_tb_top.sv ----
`timescale 1ns/1ps
module bms_boot_mode_select_tb_top;
  logic       mclk = 0, resetn = 0, want = 1, i2c_opt_wr = 0;
  logic       prog_sel_pin, i2c_sda_in, i2c_scl_in, prog_mode, i2c_prog_en, boot_done;
  logic       opt_wr_ack, i2c_sda_prog, i2c_scl_prog;
  logic [1:0] i2c_opt_addr = 2'h0, clk_mode;
  logic [7:0] i2c_opt_wdata = 8'h00, opt_byte0;
  logic [10:0] rows [8] = '{11'h403, 11'h300, 11'h401, 11'h100,
                            11'h402, 11'h200, 11'h400, 11'h000};
  int         bad_count = 0, n_checks = 0;
  bms_boot_mode_select uut (
    .mclk          (mclk),
    .resetn        (resetn),
    .prog_sel_pin  (prog_sel_pin),
    .i2c_opt_wr    (i2c_opt_wr),
    .i2c_opt_addr  (i2c_opt_addr),
    .i2c_opt_wdata (i2c_opt_wdata),
    .i2c_sda_in    (i2c_sda_in),
    .i2c_scl_in    (i2c_scl_in),
    .prog_mode     (prog_mode),
    .i2c_prog_en   (i2c_prog_en),
    .boot_done     (boot_done),
    .clk_mode      (clk_mode),
    .opt_wr_ack    (opt_wr_ack),
    .opt_byte0     (opt_byte0),
    .i2c_sda_prog  (i2c_sda_prog),
    .i2c_scl_prog  (i2c_scl_prog)
  );
  bms_tool u_tool (.mclk(mclk), .want(want), .sel(prog_sel_pin), .sda(i2c_sda_in),
                   .scl(i2c_scl_in));
  initial forever #50 mclk = ~mclk;
  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic boot(input logic s);
    resetn = 1'b0;
    want = s;
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 20 && boot_done !== 1'b1; i++) @(negedge mclk);
    chk(boot_done, 1'b1);
    if (boot_done !== 1'b1) results();
  endtask : boot
  task automatic wr(input logic [7:0] d, input logic e);
    i2c_opt_wdata = d;
    i2c_opt_wr = 1'b1;
    @(negedge mclk);
    i2c_opt_wr = 1'b0;
    chk(opt_wr_ack, e);
    if (e) chk(opt_byte0, d);
  endtask : wr
  initial begin
    foreach (rows[k]) begin
      boot(rows[k][10]);
      chk(prog_mode, rows[k][10]);
      chk(clk_mode, rows[k][9:8]);
      chk(i2c_prog_en, rows[k][10]);
      chk(i2c_scl_prog, rows[k][10]);
      if (rows[k][10]) begin
        chk(i2c_sda_prog, i2c_sda_in);
        wr(rows[k][7:0], 1'b1);
      end
    end
    wr(8'hA5, 1'b0);
    chk(opt_byte0, 8'h00);
    want = 1'b1;
    repeat (8) @(negedge mclk);
    chk(prog_mode, 1'b0);
    boot(1'b1);
    chk(prog_mode, 1'b1);
    i2c_opt_addr = 2'h1;
    i2c_opt_wdata = 8'h5A;
    i2c_opt_wr = 1'b1;
    @(negedge mclk);
    i2c_opt_wr = 1'b0;
    chk(opt_wr_ack, 1'b1);
    chk(opt_byte0, 8'h00);
    results();
  end
endmodule : bms_boot_mode_select_tb_top
